// *** cbs_pkg.sv ***
// Shared types and constants for the branch, flags and CPU state block
package cbs_pkg;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_BRANCH,
		OP_CALL,
		OP_RETURN,
		OP_RTE,
		OP_SLEEP,
		OP_LOAD_FLAGS_IMM,
		OP_LOAD_FLAGS_REG,
		OP_STORE_FLAGS,
		OP_AND_FLAGS,
		OP_OR_FLAGS,
		OP_XOR_FLAGS,
		OP_BLOCK_MOVE
	} cbs_op_t;

	typedef enum logic [1:0] {
		TOP_EXEC,
		TOP_EXCEPTION,
		TOP_POWER_DOWN
	} cbs_top_t;

	typedef enum logic [1:0] {
		PD_NONE,
		PD_SLEEP,
		PD_SOFT_STANDBY,
		PD_HW_STANDBY
	} cbs_pd_t;

	typedef enum logic [1:0] {
		KIND_CALL,
		KIND_RETURN,
		KIND_RTE,
		KIND_EXCEPTION
	} cbs_kind_t;

	// Flag bit positions
	localparam int FLAG_I = 7;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;
	localparam logic [7:0] FLAGS_RESET = 8'h80;

	// Condition codes
	localparam logic [3:0] CC_ALWAYS = 4'h0;
	localparam logic [3:0] CC_NEVER = 4'h1;
	localparam logic [3:0] CC_HI = 4'h2;
	localparam logic [3:0] CC_LS = 4'h3;
	localparam logic [3:0] CC_CC = 4'h4;
	localparam logic [3:0] CC_CS = 4'h5;
	localparam logic [3:0] CC_NE = 4'h6;
	localparam logic [3:0] CC_EQ = 4'h7;
	localparam logic [3:0] CC_VC = 4'h8;
	localparam logic [3:0] CC_VS = 4'h9;
	localparam logic [3:0] CC_PL = 4'ha;
	localparam logic [3:0] CC_MI = 4'hb;
	localparam logic [3:0] CC_GE = 4'hc;
	localparam logic [3:0] CC_LT = 4'hd;
	localparam logic [3:0] CC_GT = 4'he;
	localparam logic [3:0] CC_LE = 4'hf;

	// Program counter and pointer steps
	localparam logic [15:0] PC_STEP = 16'h0002;
	localparam logic [15:0] PTR_STEP = 16'h0001;
	localparam logic [7:0] COUNT_STEP = 8'h01;
	localparam logic [7:0] COUNT_ZERO = 8'h00;

	// System control register
	localparam int SCR_SOFT_STANDBY_SELECT_BIT = 7;
	localparam logic [7:0] SCR_RESET = 8'h09;
	localparam logic [7:0] SCR_WR_MASK = 8'hf7;

	// Stack sequencing: push slots 0..2 are pc low, pc high, flags
	localparam logic [1:0] SLOT_PC_LO = 2'h0;
	localparam logic [1:0] SLOT_PC_HI = 2'h1;
	localparam logic [1:0] SLOT_FLAGS = 2'h2;
	localparam logic [1:0] STEP_FIRST = 2'h0;
	localparam logic [1:0] STEP_ONE = 2'h1;
	localparam logic [1:0] LAST_STEP_TWO_BYTES = 2'h1;
	localparam logic [1:0] LAST_STEP_THREE_BYTES = 2'h2;

endpackage : cbs_pkg

// *** cbs_cond_eval.sv ***
// Branch condition decoder over the flags byte
module cbs_cond_eval (
	// Condition field and flags
	input wire logic [3:0] cond_code,
	input wire logic [7:0] flags,
	// Result
	output logic cond_true
);
	import cbs_pkg::*;

	logic c_f;
	logic z_f;
	logic v_f;
	logic n_f;

	assign c_f = flags[FLAG_C];
	assign z_f = flags[FLAG_Z];
	assign v_f = flags[FLAG_V];
	assign n_f = flags[FLAG_N];

	always_comb begin
		case (cond_code)
			CC_ALWAYS: cond_true = 1'b1;
			CC_NEVER: cond_true = 1'b0;
			CC_HI: cond_true = ~(c_f | z_f);
			CC_LS: cond_true = c_f | z_f;
			CC_CC: cond_true = ~c_f;
			CC_CS: cond_true = c_f;
			CC_NE: cond_true = ~z_f;
			CC_EQ: cond_true = z_f;
			CC_VC: cond_true = ~v_f;
			CC_VS: cond_true = v_f;
			CC_PL: cond_true = ~n_f;
			CC_MI: cond_true = n_f;
			CC_GE: cond_true = ~(n_f ^ v_f);
			CC_LT: cond_true = n_f ^ v_f;
			CC_GT: cond_true = ~(z_f | (n_f ^ v_f));
			CC_LE: cond_true = z_f | (n_f ^ v_f);
			default: cond_true = 1'b0;
		endcase
	end

endmodule : cbs_cond_eval

// *** cbs_cpu_core.sv ***
// Branch, system-control, block-move and CPU state sequencer
// Summary of operation
// - Conditional branch taken when the 4-bit condition code evaluates true.
// - Exception return pops flags and program counter, resuming interrupted flow.
// - Sleep instruction leaves program execution and enters power-down.
// - Load flags writes the flags byte from immediate or general register.
// - Store flags copies the flags byte to the destination register.
// - AND, OR, XOR of flags with immediate byte written back.
// - No-operation only advances the program counter by two.
// - Block move copies bytes source to destination until count is zero.
// - Next instruction starts only after the whole block transfer ends.
// - Three top states: execution, exception, power-down with three modes.
// - Reset or interrupt enters exception handling; interrupts push pc and flags.
// - Sleep halts the CPU, keeps registers, peripherals keep running.
// - Software standby halts and initialises peripherals, keeps registers and ports.
// - Hardware standby pin low halts everything including port drive.
// - Standby select is bit 7 of system control, reset zero.
module cbs_cpu_core #(
	parameter logic [15:0] RESET_VECTOR = 16'h0000,
	parameter logic [15:0] SP_RESET = 16'hff80
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Instruction stream
	input wire logic instr_valid,
	input wire cbs_pkg::cbs_op_t instr_op,
	input wire logic [3:0] instr_cond,
	input wire logic [7:0] instr_imm,
	input wire logic [15:0] instr_target,
	input wire logic [7:0] instr_reg_byte,
	input wire logic [7:0] instr_move_count,
	input wire logic [15:0] instr_move_src,
	input wire logic [15:0] instr_move_dst,
	output logic instr_ready,
	// Register write-back of the flags byte
	output logic store_valid,
	output logic [7:0] store_data,
	// Interrupts
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	output logic irq_ack,
	// Byte memory bus
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack,
	// System control register
	input wire logic scr_wr_en,
	input wire logic [7:0] scr_wr_data,
	output logic [7:0] system_control_reg,
	// Hardware standby pin
	input wire logic hw_standby_pin_n,
	// Architectural state
	output logic [15:0] pc,
	output logic [7:0] flags_register,
	output logic [15:0] stack_ptr_reg,
	output logic [7:0] move_count_reg,
	output logic [15:0] move_source_ptr,
	output logic [15:0] move_dest_ptr,
	// CPU state and power control
	output cbs_pkg::cbs_top_t cpu_state,
	output cbs_pkg::cbs_pd_t pd_mode,
	output logic cpu_halt,
	output logic periph_halt,
	output logic periph_init,
	output logic port_drive_en
);
	import cbs_pkg::*;

	typedef enum logic [3:0] {
		SEQ_RESET_EXC,
		SEQ_EXEC,
		SEQ_PUSH,
		SEQ_POP,
		SEQ_MOVE_RD,
		SEQ_MOVE_WR,
		SEQ_SLEEP,
		SEQ_SOFT_HW_STANDBY_PIN_N,
		SEQ_HW_HW_STANDBY_PIN_N
	} cbs_seq_t;

	cbs_seq_t seq_ff, nxt_seq;
	cbs_kind_t kind_ff, nxt_kind;
	logic [1:0] step_ff, nxt_step;
	logic [15:0] pc_ff, nxt_pc;
	logic [15:0] tgt_ff, nxt_tgt;
	logic [7:0] flags_ff, nxt_flags;
	logic [15:0] sp_ff, nxt_sp;
	logic [7:0] cnt_ff, nxt_cnt;
	logic [15:0] src_ff, nxt_src;
	logic [15:0] dst_ff, nxt_dst;
	logic [7:0] scr_ff, nxt_scr;
	logic req_ff, nxt_req;
	logic we_ff, nxt_we;
	logic [15:0] addr_ff, nxt_addr;
	logic [7:0] wdata_ff, nxt_wdata;
	logic store_valid_ff, nxt_store_valid;
	logic [7:0] store_data_ff, nxt_store_data;
	logic irq_ack_ff, nxt_irq_ack;
	cbs_top_t top_ff, nxt_top;
	cbs_pd_t pd_ff, nxt_pd;
	logic hw_standby_pin_n_meta_ff;
	logic hw_standby_pin_n_sync_ff;
	logic cond_true;
	logic irq_pending;
	logic [1:0] slot;

	// Two-stage synchroniser for the standby pin
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hw_standby_pin_n_meta_ff <= 1'b1;
			hw_standby_pin_n_sync_ff <= 1'b1;
		end else begin
			hw_standby_pin_n_meta_ff <= hw_standby_pin_n;
			hw_standby_pin_n_sync_ff <= hw_standby_pin_n_meta_ff;
		end
	end

	cbs_cond_eval u_cond (
		.cond_code(instr_cond),
		.flags(flags_ff),
		.cond_true(cond_true)
	);

	assign irq_pending = irq_req & ~flags_ff[FLAG_I];

	function automatic logic [1:0] last_step(input cbs_kind_t kind);
		case (kind)
			KIND_CALL: last_step = LAST_STEP_TWO_BYTES;
			KIND_RETURN: last_step = LAST_STEP_TWO_BYTES;
			default: last_step = LAST_STEP_THREE_BYTES;
		endcase
	endfunction : last_step

	function automatic cbs_top_t top_of(input cbs_seq_t s);
		case (s)
			SEQ_EXEC, SEQ_MOVE_RD, SEQ_MOVE_WR: top_of = TOP_EXEC;
			SEQ_SLEEP, SEQ_SOFT_HW_STANDBY_PIN_N, SEQ_HW_HW_STANDBY_PIN_N: top_of = TOP_POWER_DOWN;
			default: top_of = TOP_EXCEPTION;
		endcase
	endfunction : top_of

	function automatic cbs_pd_t pd_of(input cbs_seq_t s);
		case (s)
			SEQ_SLEEP: pd_of = PD_SLEEP;
			SEQ_SOFT_HW_STANDBY_PIN_N: pd_of = PD_SOFT_STANDBY;
			SEQ_HW_HW_STANDBY_PIN_N: pd_of = PD_HW_STANDBY;
			default: pd_of = PD_NONE;
		endcase
	endfunction : pd_of

	// Pops arrive in reverse push order; a return has no flags byte to skip
	assign slot = (kind_ff == KIND_RETURN) ? (step_ff + STEP_ONE) : step_ff;

	always_comb begin
		nxt_seq = seq_ff;
		nxt_kind = kind_ff;
		nxt_step = step_ff;
		nxt_pc = pc_ff;
		nxt_tgt = tgt_ff;
		nxt_flags = flags_ff;
		nxt_sp = sp_ff;
		nxt_cnt = cnt_ff;
		nxt_src = src_ff;
		nxt_dst = dst_ff;
		nxt_scr = scr_ff;
		nxt_req = req_ff;
		nxt_we = we_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_store_valid = 1'b0;
		nxt_store_data = store_data_ff;
		nxt_irq_ack = 1'b0;
		if (scr_wr_en) begin
			nxt_scr = (scr_ff & ~SCR_WR_MASK) | (scr_wr_data & SCR_WR_MASK);
		end
		case (seq_ff)
			SEQ_RESET_EXC: begin
				nxt_pc = RESET_VECTOR;
				nxt_flags[FLAG_I] = 1'b1;
				nxt_sp = SP_RESET;
				nxt_seq = SEQ_EXEC;
			end
			SEQ_EXEC: begin
				if (irq_pending) begin
					nxt_irq_ack = 1'b1;
					nxt_tgt = irq_vector;
					nxt_kind = KIND_EXCEPTION;
					nxt_step = STEP_FIRST;
					nxt_seq = SEQ_PUSH;
				end else if (instr_valid) begin
					nxt_pc = pc_ff + PC_STEP;
					case (instr_op)
						OP_BRANCH: begin
							if (cond_true) begin
								nxt_pc = instr_target;
							end
						end
						OP_CALL: begin
							nxt_tgt = instr_target;
							nxt_kind = KIND_CALL;
							nxt_step = STEP_FIRST;
							nxt_seq = SEQ_PUSH;
						end
						OP_RETURN: begin
							nxt_kind = KIND_RETURN;
							nxt_step = STEP_FIRST;
							nxt_seq = SEQ_POP;
						end
						OP_RTE: begin
							nxt_kind = KIND_RTE;
							nxt_step = STEP_FIRST;
							nxt_seq = SEQ_POP;
						end
						OP_SLEEP: begin
							// Select bit chooses sleep or software standby
							nxt_seq = scr_ff[SCR_SOFT_STANDBY_SELECT_BIT] ? SEQ_SOFT_HW_STANDBY_PIN_N : SEQ_SLEEP;
						end
						OP_LOAD_FLAGS_IMM: nxt_flags = instr_imm;
						OP_LOAD_FLAGS_REG: nxt_flags = instr_reg_byte;
						OP_STORE_FLAGS: begin
							nxt_store_valid = 1'b1;
							nxt_store_data = flags_ff;
						end
						OP_AND_FLAGS: nxt_flags = flags_ff & instr_imm;
						OP_OR_FLAGS: nxt_flags = flags_ff | instr_imm;
						OP_XOR_FLAGS: nxt_flags = flags_ff ^ instr_imm;
						OP_BLOCK_MOVE: begin
							if (instr_move_count != COUNT_ZERO) begin
								nxt_cnt = instr_move_count;
								nxt_src = instr_move_src;
								nxt_dst = instr_move_dst;
								nxt_seq = SEQ_MOVE_RD;
							end
						end
						default: ;
					endcase
				end
			end
			SEQ_PUSH: begin
				if (!req_ff) begin
					nxt_req = 1'b1;
					nxt_we = 1'b1;
					nxt_addr = sp_ff - PTR_STEP;
					nxt_sp = sp_ff - PTR_STEP;
					case (step_ff)
						SLOT_PC_LO: nxt_wdata = pc_ff[7:0];
						SLOT_PC_HI: nxt_wdata = pc_ff[15:8];
						default: nxt_wdata = flags_ff;
					endcase
				end else if (mem_ack) begin
					nxt_req = 1'b0;
					if (step_ff == last_step(kind_ff)) begin
						nxt_pc = tgt_ff;
						if (kind_ff == KIND_EXCEPTION) begin
							nxt_flags[FLAG_I] = 1'b1;
						end
						nxt_seq = SEQ_EXEC;
					end else begin
						nxt_step = step_ff + STEP_ONE;
					end
				end
			end
			SEQ_POP: begin
				if (!req_ff) begin
					nxt_req = 1'b1;
					nxt_we = 1'b0;
					nxt_addr = sp_ff;
					nxt_sp = sp_ff + PTR_STEP;
				end else if (mem_ack) begin
					nxt_req = 1'b0;
					case (slot)
						SLOT_PC_LO: nxt_flags = mem_rdata;
						SLOT_PC_HI: nxt_pc[15:8] = mem_rdata;
						default: nxt_pc[7:0] = mem_rdata;
					endcase
					if (step_ff == last_step(kind_ff)) begin
						nxt_seq = SEQ_EXEC;
					end else begin
						nxt_step = step_ff + STEP_ONE;
					end
				end
			end
			SEQ_MOVE_RD: begin
				if (!req_ff) begin
					nxt_req = 1'b1;
					nxt_we = 1'b0;
					nxt_addr = src_ff;
				end else if (mem_ack) begin
					nxt_req = 1'b0;
					nxt_wdata = mem_rdata;
					nxt_seq = SEQ_MOVE_WR;
				end
			end
			SEQ_MOVE_WR: begin
				if (!req_ff) begin
					nxt_req = 1'b1;
					nxt_we = 1'b1;
					// Destination is not wrapped by hardware; software keeps it in range
					nxt_addr = dst_ff;
				end else if (mem_ack) begin
					nxt_req = 1'b0;
					nxt_src = src_ff + PTR_STEP;
					nxt_dst = dst_ff + PTR_STEP;
					nxt_cnt = cnt_ff - COUNT_STEP;
					nxt_seq = (cnt_ff == COUNT_STEP) ? SEQ_EXEC : SEQ_MOVE_RD;
				end
			end
			SEQ_SLEEP, SEQ_SOFT_HW_STANDBY_PIN_N: begin
				// Registers hold; only an unmasked interrupt wakes the core
				if (irq_pending) begin
					nxt_irq_ack = 1'b1;
					nxt_tgt = irq_vector;
					nxt_kind = KIND_EXCEPTION;
					nxt_step = STEP_FIRST;
					nxt_seq = SEQ_PUSH;
				end
			end
			SEQ_HW_HW_STANDBY_PIN_N: begin
				if (hw_standby_pin_n_sync_ff) begin
					nxt_seq = SEQ_RESET_EXC;
				end
			end
			default: nxt_seq = SEQ_RESET_EXC;
		endcase
		// Standby pin overrides the next state, irq_ack and store_valid, and abandons any bus cycle
		if (!hw_standby_pin_n_sync_ff) begin
			nxt_seq = SEQ_HW_HW_STANDBY_PIN_N;
			nxt_req = 1'b0;
			nxt_irq_ack = 1'b0;
			nxt_store_valid = 1'b0;
		end
	end

	assign nxt_top = top_of(nxt_seq);
	assign nxt_pd = pd_of(nxt_seq);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			seq_ff <= SEQ_RESET_EXC;
			kind_ff <= KIND_CALL;
			step_ff <= STEP_FIRST;
			pc_ff <= RESET_VECTOR;
			tgt_ff <= RESET_VECTOR;
			flags_ff <= FLAGS_RESET;
			sp_ff <= SP_RESET;
			cnt_ff <= COUNT_ZERO;
			src_ff <= '0;
			dst_ff <= '0;
			scr_ff <= SCR_RESET;
			req_ff <= 1'b0;
			we_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= '0;
			store_valid_ff <= 1'b0;
			store_data_ff <= '0;
			irq_ack_ff <= 1'b0;
			top_ff <= TOP_EXCEPTION;
			pd_ff <= PD_NONE;
		end else begin
			seq_ff <= nxt_seq;
			kind_ff <= nxt_kind;
			step_ff <= nxt_step;
			pc_ff <= nxt_pc;
			tgt_ff <= nxt_tgt;
			flags_ff <= nxt_flags;
			sp_ff <= nxt_sp;
			cnt_ff <= nxt_cnt;
			src_ff <= nxt_src;
			dst_ff <= nxt_dst;
			scr_ff <= nxt_scr;
			req_ff <= nxt_req;
			we_ff <= nxt_we;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			store_valid_ff <= nxt_store_valid;
			store_data_ff <= nxt_store_data;
			irq_ack_ff <= nxt_irq_ack;
			top_ff <= nxt_top;
			pd_ff <= nxt_pd;
		end
	end

	assign instr_ready = (seq_ff == SEQ_EXEC) & ~irq_pending & hw_standby_pin_n_sync_ff;
	assign store_valid = store_valid_ff;
	assign store_data = store_data_ff;
	assign irq_ack = irq_ack_ff;
	assign mem_req = req_ff;
	assign mem_we = we_ff;
	assign mem_addr = addr_ff;
	assign mem_wdata = wdata_ff;
	assign system_control_reg = scr_ff;
	assign pc = pc_ff;
	assign flags_register = flags_ff;
	assign stack_ptr_reg = sp_ff;
	assign move_count_reg = cnt_ff;
	assign move_source_ptr = src_ff;
	assign move_dest_ptr = dst_ff;
	assign cpu_state = top_ff;
	assign pd_mode = pd_ff;
	assign cpu_halt = (top_ff == TOP_POWER_DOWN);
	assign periph_halt = (pd_ff == PD_SOFT_STANDBY) | (pd_ff == PD_HW_STANDBY);
	assign periph_init = periph_halt;
	assign port_drive_en = (pd_ff != PD_HW_STANDBY);

endmodule : cbs_cpu_core

// *** cbs_mem_model.sv ***
// Byte memory that answers the core's bus, promptly or after a wait
module cbs_mem_model (
	// Clock, reset and pacing
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	// Byte bus
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic mem_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [7:0] rd_ff = 8'h5a;
	logic [1:0] wait_ff = 2'h0;
	// Read bus toggles outside the ack cycle so a late sample shows up
	assign mem_rdata = mem_ack ? rd_ff : ~rd_ff;
	always @(posedge clk) begin
		if (!rst_b || !mem_req || mem_ack) begin
			wait_ff <= 2'h0;
			mem_ack <= 1'b0;
			rd_ff <= ~rd_ff;
		end else if (slow && wait_ff != 2'h3) begin
			wait_ff <= wait_ff + 2'h1;
		end else begin
			mem_ack <= 1'b1;
			rd_ff <= mem[mem_addr];
			if (mem_we) begin
				mem[mem_addr] <= mem_wdata;
			end
		end
	end
endmodule : cbs_mem_model

// *** cbs_cpu_core_assertions.sv ***
// Port checks for the branch, flags and CPU state core
module cbs_cpu_core_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Instruction side
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire cbs_pkg::cbs_op_t instr_op,
	input wire logic [3:0] instr_cond,
	input wire logic [7:0] instr_imm,
	input wire logic [15:0] instr_target,
	input wire logic store_valid,
	input wire logic [7:0] store_data,
	input wire logic mem_req,
	// State
	input wire logic [7:0] system_control_reg,
	input wire logic hw_standby_pin_n,
	input wire logic [15:0] pc,
	input wire logic [7:0] flags_register,
	input wire cbs_pkg::cbs_top_t cpu_state,
	input wire cbs_pkg::cbs_pd_t pd_mode,
	input wire logic cpu_halt,
	input wire logic periph_halt,
	input wire logic port_drive_en
);
	import cbs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic take;
	assign take = instr_valid && instr_ready;
	nop_pc_step_a: assert property (take && instr_op == OP_NOP |=> pc == $past(pc) + PC_STEP)
		else $error("nop step wrong");
	branch_always_a: assert property (take && instr_op == OP_BRANCH && instr_cond == CC_ALWAYS
		|=> pc == $past(instr_target)) else $error("branch not taken");
	branch_never_a: assert property (take && instr_op == OP_BRANCH && instr_cond == CC_NEVER
		|=> pc == $past(pc) + PC_STEP && $stable(flags_register)) else $error("false branch moved");
	flags_and_a: assert property (take && instr_op == OP_AND_FLAGS
		|=> flags_register == ($past(flags_register) & $past(instr_imm))) else $error("and flags");
	flags_load_a: assert property (take && instr_op == OP_LOAD_FLAGS_IMM
		|=> flags_register == $past(instr_imm)) else $error("load flags");
	store_copy_a: assert property (take && instr_op == OP_STORE_FLAGS
		|=> store_valid && store_data == $past(flags_register)) else $error("store flags");
	sleep_entry_a: assert property (take && instr_op == OP_SLEEP |=> cpu_state == TOP_POWER_DOWN
		&& pd_mode == ($past(system_control_reg[7]) ? PD_SOFT_STANDBY : PD_SLEEP))
		else $error("sleep entry");
	move_blocks_a: assert property (mem_req |-> !instr_ready) else $error("ready in move");
	sleep_halt_a: assert property (pd_mode == PD_SLEEP |-> cpu_halt && !periph_halt)
		else $error("sleep halt");
	soft_halt_a: assert property (pd_mode == PD_SOFT_STANDBY |-> periph_halt && port_drive_en)
		else $error("soft standby halt");
	hw_standby_a: assert property (!hw_standby_pin_n [*5] |-> pd_mode == PD_HW_STANDBY
		&& !port_drive_en) else $error("hw standby");
	reset_entry_a: assert property ($rose(rst_b) |-> cpu_state == TOP_EXCEPTION
		##1 cpu_state == TOP_EXEC) else $error("reset entry");
	cover property (take && instr_op == OP_BLOCK_MOVE);
	cover property (pd_mode == PD_SOFT_STANDBY);
	cover property (pd_mode == PD_HW_STANDBY);
endmodule : cbs_cpu_core_assertions

// *** cbs_cpu_core_tb_top.sv ***
// Self-checking bench for the branch, flags and CPU state core
module cbs_cpu_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cbs_pkg::*;
	logic clk = 0, rst_b = 0, instr_valid = 0, irq_req = 0, scr_wr_en = 0, slow = 0;
	logic hw_standby_pin_n = 1;
	cbs_op_t instr_op = OP_NOP;
	logic [3:0] instr_cond = '0;
	logic [7:0] instr_imm = '0, instr_reg_byte = '0, instr_move_count = '0, scr_wr_data = '0;
	logic [15:0] instr_target = '0, instr_move_src = '0, instr_move_dst = '0, irq_vector = '0;
	logic instr_ready, store_valid, irq_ack, mem_req, mem_we, mem_ack, cpu_halt, periph_halt;
	logic periph_init, port_drive_en, sv_seen;
	logic [7:0] store_data, mem_wdata, mem_rdata, system_control_reg, flags_register;
	logic [7:0] move_count_reg, sd_seen;
	logic [15:0] mem_addr, pc, stack_ptr_reg, move_source_ptr, move_dest_ptr;
	cbs_top_t cpu_state;
	cbs_pd_t pd_mode;
	int err_total = 0, check_count = 0, cycles = 0, m_pc, m_flags, m_sp;
	logic [31:0] seed = 32'h3169_8c0a, v;
	cbs_op_t ops [4] = '{OP_LOAD_FLAGS_REG, OP_AND_FLAGS, OP_OR_FLAGS, OP_XOR_FLAGS};
	always #10 clk = ~clk;
	cbs_cpu_core i_dut (.*);
	cbs_mem_model i_mem (.*);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic cond_ok(input logic [3:0] c, input logic [7:0] f);
		logic b;
		case (c[3:1])
			3'h0: b = 1'b1;
			3'h1: b = !(f[0] | f[2]);
			3'h2: b = !f[0];
			3'h3: b = !f[2];
			3'h4: b = !f[1];
			3'h5: b = !f[3];
			3'h6: b = !(f[3] ^ f[1]);
			default: b = !(f[2] | (f[3] ^ f[1]));
		endcase
		return b ^ c[0];
	endfunction : cond_ok
	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_st(input cbs_top_t st, input cbs_pd_t md);
		chk({14'h0, cpu_state}, {14'h0, st});
		chk({14'h0, pd_mode}, {14'h0, md});
	endtask : chk_st
	task automatic wait_ready();
		int n;
		n = 0;
		@(negedge clk);
		while (instr_ready !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0, instr_ready}, 16'h0001);
	endtask : wait_ready
	task automatic arch();
		wait_ready();
		chk(pc, 16'(m_pc));
		chk({8'h0, flags_register}, 16'(m_flags));
		chk(stack_ptr_reg, 16'(m_sp));
	endtask : arch
	task automatic issue(input cbs_op_t op, input logic [7:0] imm, input logic [15:0] tgt);
		@(posedge clk);
		instr_op <= op;
		instr_imm <= imm;
		instr_reg_byte <= imm;
		instr_cond <= imm[3:0];
		instr_move_count <= imm;
		instr_target <= tgt;
		instr_move_src <= tgt;
		instr_move_dst <= tgt + 16'h1000;
		instr_valid <= 1'b1;
		wait_ready();
		@(posedge clk);
		instr_valid <= 1'b0;
		@(negedge clk);
		sv_seen = store_valid;
		sd_seen = store_data;
	endtask : issue
	task automatic irq_rte(input logic [15:0] vec);
		int n, s_pc, s_fl;
		n = 0;
		s_pc = m_pc;
		s_fl = m_flags;
		@(posedge clk);
		irq_req <= 1'b1;
		irq_vector <= vec;
		@(negedge clk);
		while (irq_ack !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0, irq_ack}, 16'h0001);
		@(posedge clk);
		irq_req <= 1'b0;
		m_sp -= 3;
		m_flags |= 8'h80;
		m_pc = vec;
		arch();
		issue(OP_RTE, 8'h00, 16'h0000);
		m_sp += 3;
		m_pc = s_pc;
		m_flags = s_fl;
		arch();
	endtask : irq_rte
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(pc, 16'h0000);
		chk({8'h0, flags_register}, 16'h0080);
		chk(stack_ptr_reg, 16'hff80);
		chk({8'h0, system_control_reg}, 16'h0009);
		chk_st(TOP_EXCEPTION, PD_NONE);
		@(posedge clk);
		rst_b <= 1'b1;
		m_pc = 0;
		m_flags = 8'h80;
		m_sp = 16'hff80;
		issue(OP_NOP, 8'h00, 16'h0000);
		m_pc += 2;
		arch();
		for (int c = 0; c < 16; c++) begin
			v = rnd();
			issue(OP_LOAD_FLAGS_IMM, v[7:0], 16'h0000);
			m_pc += 2;
			m_flags = v[7:0];
			arch();
			issue(OP_BRANCH, 8'(c), v[23:8]);
			m_pc = cond_ok(4'(c), 8'(m_flags)) ? v[23:8] : m_pc + 2;
			arch();
		end
		for (int k = 0; k < 4; k++) begin
			v = rnd();
			issue(ops[k], v[7:0], 16'h0000);
			m_pc += 2;
			case (k)
				0: m_flags = v[7:0];
				1: m_flags &= v[7:0];
				2: m_flags |= v[7:0];
				default: m_flags ^= v[7:0];
			endcase
			arch();
			issue(OP_STORE_FLAGS, 8'h00, 16'h0000);
			m_pc += 2;
			chk({15'h0, sv_seen}, 16'h0001);
			chk({8'h0, sd_seen}, 16'(m_flags));
		end
		slow = 1'b1;
		v = m_pc + 2;
		issue(OP_CALL, 8'h00, 16'h4000);
		m_sp -= 2;
		m_pc = 16'h4000;
		arch();
		issue(OP_RETURN, 8'h00, 16'h0000);
		m_sp += 2;
		m_pc = v;
		arch();
		for (int i = 0; i < 3; i++) begin
			i_mem.mem[16'h1000 + i] = 8'(rnd());
		end
		i_mem.mem[16'h4000] = 8'h5a;
		issue(OP_BLOCK_MOVE, 8'h03, 16'h1000);
		m_pc += 2;
		arch();
		chk(move_dest_ptr, 16'h2003);
		chk(move_source_ptr, 16'h1003);
		chk({8'h0, move_count_reg}, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			chk({8'h0, i_mem.mem[16'h2000 + i]}, {8'h0, i_mem.mem[16'h1000 + i]});
		end
		issue(OP_BLOCK_MOVE, 8'h00, 16'h3000);
		m_pc += 2;
		arch();
		chk({8'h0, i_mem.mem[16'h4000]}, 16'h005a);
		slow = 1'b0;
		issue(OP_LOAD_FLAGS_IMM, 8'h05, 16'h0000);
		m_pc += 2;
		m_flags = 8'h05;
		irq_rte(16'h6000);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			scr_wr_en <= 1'b1;
			scr_wr_data <= s ? 8'h80 : 8'h00;
			@(posedge clk);
			scr_wr_en <= 1'b0;
			@(negedge clk);
			chk({8'h0, system_control_reg}, s ? 16'h0088 : 16'h0008);
			issue(OP_SLEEP, 8'h00, 16'h0000);
			m_pc += 2;
			chk_st(TOP_POWER_DOWN, s ? PD_SOFT_STANDBY : PD_SLEEP);
			chk({12'h0, port_drive_en, cpu_halt, periph_halt, periph_init},
				s ? 16'h000f : 16'h000c);
			chk(pc, 16'(m_pc));
			irq_rte(16'h7000 + 16'(s));
		end
		@(posedge clk);
		hw_standby_pin_n <= 1'b0;
		repeat (5) @(negedge clk);
		chk_st(TOP_POWER_DOWN, PD_HW_STANDBY);
		chk({12'h0, port_drive_en, cpu_halt, periph_halt, periph_init}, 16'h0007);
		@(posedge clk);
		hw_standby_pin_n <= 1'b1;
		wait_ready();
		chk(pc, 16'h0000);
		// Standby exit runs the reset exception: only the mask bit is forced, other flags hold
		chk({8'h0, flags_register}, 16'(m_flags | 8'h80));
		chk(stack_ptr_reg, 16'hff80);
		tally_and_finish();
	end
endmodule : cbs_cpu_core_tb_top
bind cbs_cpu_core cbs_cpu_core_assertions i_chk (.*);
